// ### pvr_regs.sv
// Functional notes
// - mode field bits 7:5, survives soft reset
// - station address bits 4:0, default 00001
// - mode 000: 10 half, control 0000
// - mode 001: 10 full, control 0001
// - mode 010: 100 half, crs tx+rx, 1000
// - mode 011: 100 full, crs rx, 1001
// - mode 100: negotiate 100 half, 1100/0100
// - mode 101: repeater, negotiate, 1100/0100
// - mode 111: negotiate all, X10X/1111
// - pll lock bit 10, survives soft reset
// - polarity reversed shown in bit 4
// - bits 3:0 read 1011, writes ignored
// - flags 7..5: energy, negotiated, remote fault
// - flags 4..1: link down, ack, fault, page
// - mask bits 7:1 enable sources, bit 0 stored only, reset 0
// - done bit 12 only when negotiation finished
// - energy drops after 256 ms silence
`timescale 1ns/1ns
module pvr_regs
    import pvr_pkg::*;
#(
    parameter int ENERGY_CYCLES = ENERGY_TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic soft_rst,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic energy_seen,
    input wire logic an_enable,
    input wire logic an_complete,
    input wire logic remote_fault,
    input wire logic link_up,
    input wire logic partner_ack,
    input wire logic parallel_detect_fault,
    input wire logic page_received,
    input wire logic polarity_reversed_in,
    input wire logic link_speed_100,
    input wire logic link_full_duplex,
    output logic irq,
    output logic line_energy_present,
    output logic [2:0] mode_reg,
    output logic [4:0] station_address_field_reg,
    output logic force_10m_pll_reference_lock_reg,
    output logic [3:0] ctrl_default_reg,
    output logic [3:0] adv_default_reg,
    output logic crs_on_transmit_reg,
    output logic repeater_mode_reg
);
    // ********************************
    // management pin synchronisers
    // ********************************
    logic mdc_s;
    logic mdio_s;
    logic mdc_d_reg;
    logic mdc_rise;

    pvr_sync #(.WIDTH(2)) u_sync (
        .clk(clk),
        .rst(rst),
        .d({mdc, mdio_in}),
        .q({mdc_s, mdio_s})
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            mdc_d_reg <= 1'b0;
        end else begin
            mdc_d_reg <= mdc_s;
        end
    end

    assign mdc_rise = mdc_s & ~mdc_d_reg;

    // ********************************
    // energy detection
    // ********************************
    pvr_energy #(.TIMEOUT_CYCLES(ENERGY_CYCLES)) u_energy (
        .clk(clk),
        .rst(rst),
        .energy_seen(energy_seen),
        .line_energy_present(line_energy_present)
    );

    // ********************************
    // frame engine
    // ********************************
    pvr_mdio_state_t state_reg;
    logic [5:0] ones_cnt_reg;
    logic [3:0] bit_cnt_reg;
    logic [11:0] hdr_reg;
    logic [4:0] reg_addr_reg;
    logic is_read_reg;
    logic [15:0] shift_reg;
    logic [12:0] hdr_full;
    logic hdr_hit;
    logic addr_mapped;
    logic rd_fire;
    logic wr_fire;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    logic clr_on_read;

    assign hdr_full = {hdr_reg, mdio_s};
    always_comb begin
        case (hdr_full[4:0])
            REG_SPECIAL_MODES, REG_SPECIAL_CTRL, REG_IRQ_SOURCE,
            REG_IRQ_MASK, REG_PHY_SCS: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    end
    // answer only frames for our station address and our registers
    assign hdr_hit = hdr_full[12] && addr_mapped &&
        (hdr_full[9:5] == station_address_field_reg) &&
        (hdr_full[11:10] == OP_READ || hdr_full[11:10] == OP_WRITE);
    assign rd_fire = (state_reg == ST_TA) && mdc_rise &&
        (bit_cnt_reg == 4'd1) && is_read_reg;
    assign wr_fire = (state_reg == ST_WDATA) && mdc_rise &&
        (bit_cnt_reg == DATA_LAST);
    assign wr_data = {shift_reg[14:0], mdio_s};
    assign clr_on_read = rd_fire && (reg_addr_reg == REG_IRQ_SOURCE);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_PRE;
            ones_cnt_reg <= '0;
            bit_cnt_reg <= '0;
            hdr_reg <= '0;
            reg_addr_reg <= '0;
            is_read_reg <= 1'b0;
            shift_reg <= '0;
        end else if (mdc_rise) begin
            case (state_reg)
                ST_PRE: begin
                    if (mdio_s) begin
                        if (ones_cnt_reg != PREAMBLE_ONES) begin
                            ones_cnt_reg <= ones_cnt_reg + 1'b1;
                        end
                    end else begin
                        if (ones_cnt_reg == PREAMBLE_ONES) begin
                            state_reg <= ST_HDR;
                            bit_cnt_reg <= '0;
                        end
                        ones_cnt_reg <= '0;
                    end
                end
                ST_HDR: begin
                    hdr_reg <= hdr_full[11:0];
                    bit_cnt_reg <= bit_cnt_reg + 1'b1;
                    if (bit_cnt_reg == HDR_LAST) begin
                        bit_cnt_reg <= '0;
                        reg_addr_reg <= hdr_full[4:0];
                        is_read_reg <= (hdr_full[11:10] == OP_READ);
                        state_reg <= hdr_hit ? ST_TA : ST_PRE;
                    end
                end
                ST_TA: begin
                    bit_cnt_reg <= bit_cnt_reg + 1'b1;
                    if (bit_cnt_reg == 4'd1) begin
                        bit_cnt_reg <= '0;
                        shift_reg <= is_read_reg ? rd_data : 16'h0000;
                        state_reg <= is_read_reg ? ST_RDATA : ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    bit_cnt_reg <= bit_cnt_reg + 1'b1;
                    shift_reg <= {shift_reg[14:0], 1'b0};
                    if (bit_cnt_reg == DATA_LAST) begin
                        state_reg <= ST_PRE;
                    end
                end
                ST_WDATA: begin
                    bit_cnt_reg <= bit_cnt_reg + 1'b1;
                    shift_reg <= wr_data;
                    if (bit_cnt_reg == DATA_LAST) begin
                        state_reg <= ST_PRE;
                    end
                end
                default: begin
                    state_reg <= ST_PRE;
                end
            endcase
        end
    end

    // drive zero in the second turnaround bit, then sixteen data bits
    always_ff @(posedge clk) begin
        if (rst) begin
            mdio_oe <= 1'b0;
            mdio_out <= 1'b0;
        end else if (mdc_rise) begin
            if (state_reg == ST_TA && bit_cnt_reg == 4'd0 && is_read_reg) begin
                mdio_oe <= 1'b1;
                mdio_out <= 1'b0;
            end else if (rd_fire) begin
                mdio_out <= rd_data[15];
            end else if (state_reg == ST_RDATA) begin
                mdio_out <= shift_reg[14];
                if (bit_cnt_reg == DATA_LAST) begin
                    mdio_oe <= 1'b0;
                    mdio_out <= 1'b0;
                end
            end
        end
    end

    // ********************************
    // register storage
    // ********************************
    logic [7:0] modes_rsvd_reg;
    logic [4:0] sci_hi_reg;
    logic [4:0] sci_mid_reg;
    logic tenbase_polarity_reversed_reg;
    logic [7:1] flags_reg;
    logic [7:0] mask_reg;
    logic [6:0] pscs_rsvd_reg;
    logic autodone_reg;
    logic [2:0] resolved_speed_duplex_reg;
    logic [7:1] cond;
    logic [7:1] cond_d_reg;
    logic [7:1] evt;

    // mode, address and pll lock ignore soft reset
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= MODE_RESET;
            station_address_field_reg <= STATION_ADDR_RESET;
            modes_rsvd_reg <= MODES_RSVD_RESET;
            force_10m_pll_reference_lock_reg <= 1'b0;
        end else if (wr_fire && reg_addr_reg == REG_SPECIAL_MODES) begin
            mode_reg <= wr_data[MODE_MSB:MODE_LSB];
            station_address_field_reg <= wr_data[ADDR_MSB:0];
            modes_rsvd_reg <= wr_data[15:8];
        end else if (wr_fire && reg_addr_reg == REG_SPECIAL_CTRL) begin
            force_10m_pll_reference_lock_reg <= wr_data[SCI_PLL_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst || soft_rst) begin
            sci_hi_reg <= '0;
            sci_mid_reg <= '0;
            mask_reg <= '0;
            pscs_rsvd_reg <= PSCS_RSVD_RESET;
        end else if (wr_fire) begin
            if (reg_addr_reg == REG_SPECIAL_CTRL) begin
                sci_hi_reg <= wr_data[15:11];
                sci_mid_reg <= wr_data[9:5];
            end
            if (reg_addr_reg == REG_IRQ_MASK) begin
                mask_reg <= wr_data[7:0];
            end
            if (reg_addr_reg == REG_PHY_SCS) begin
                pscs_rsvd_reg <= wr_data[11:5];
            end
        end
    end

    // ********************************
    // status capture
    // ********************************
    always_ff @(posedge clk) begin
        if (rst) begin
            tenbase_polarity_reversed_reg <= 1'b0;
            autodone_reg <= 1'b0;
            resolved_speed_duplex_reg <= '0;
        end else begin
            tenbase_polarity_reversed_reg <= polarity_reversed_in;
            autodone_reg <= an_enable & an_complete;
            resolved_speed_duplex_reg <= {link_full_duplex,
                link_speed_100, ~link_speed_100};
        end
    end

    // ********************************
    // interrupt sources
    // ********************************
    assign cond = {line_energy_present, an_complete, remote_fault,
        ~link_up, partner_ack, parallel_detect_fault, page_received};

    always_ff @(posedge clk) begin
        if (rst) begin
            cond_d_reg <= COND_RESET;
        end else begin
            cond_d_reg <= cond;
        end
    end

    for (genvar i = 1; i <= 7; i++) begin : g_evt
        if (i == 7) begin : g_any
            assign evt[i] = cond[i] ^ cond_d_reg[i];
        end else begin : g_rise
            assign evt[i] = cond[i] & ~cond_d_reg[i];
        end
    end

    always_ff @(posedge clk) begin
        if (rst || soft_rst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= (flags_reg & ~{7{clr_on_read}}) | evt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || soft_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags_reg & mask_reg[7:1]);
        end
    end

    // ********************************
    // mode decode
    // ********************************
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_default_reg <= CTRL_ALL_CAPABLE;
            adv_default_reg <= ADV_ALL;
            crs_on_transmit_reg <= 1'b1;
            repeater_mode_reg <= 1'b0;
        end else begin
            crs_on_transmit_reg <= 1'b1;
            repeater_mode_reg <= 1'b0;
            adv_default_reg <= ADV_NONE;
            case (mode_reg)
                MODE_10_HALF: ctrl_default_reg <= CTRL_10_HALF;
                MODE_10_FULL: ctrl_default_reg <= CTRL_10_FULL;
                MODE_100_HALF: ctrl_default_reg <= CTRL_100_HALF;
                MODE_100_FULL: begin
                    ctrl_default_reg <= CTRL_100_FULL;
                    crs_on_transmit_reg <= 1'b0;
                end
                MODE_AN_100_HALF: begin
                    ctrl_default_reg <= CTRL_AN_100_HALF;
                    adv_default_reg <= ADV_100_HALF;
                end
                MODE_REPEATER: begin
                    ctrl_default_reg <= CTRL_AN_100_HALF;
                    adv_default_reg <= ADV_100_HALF;
                    crs_on_transmit_reg <= 1'b0;
                    repeater_mode_reg <= 1'b1;
                end
                MODE_ALL_CAPABLE: begin
                    ctrl_default_reg <= CTRL_ALL_CAPABLE;
                    adv_default_reg <= ADV_ALL;
                end
                // reserved code: control default held, advertise cleared, behaviour undefined
                default: ctrl_default_reg <= ctrl_default_reg;
            endcase
        end
    end

    // ********************************
    // read data
    // ********************************
    always_comb begin
        rd_data = 16'h0000;
        case (reg_addr_reg)
            REG_SPECIAL_MODES: rd_data = {modes_rsvd_reg, mode_reg,
                station_address_field_reg};
            REG_SPECIAL_CTRL: rd_data = {sci_hi_reg,
                force_10m_pll_reference_lock_reg, sci_mid_reg,
                tenbase_polarity_reversed_reg, SCI_FIXED_LOW};
            REG_IRQ_SOURCE: rd_data = {8'h00, flags_reg, 1'b0};
            REG_IRQ_MASK: rd_data = {8'h00, mask_reg};
            REG_PHY_SCS: rd_data = {3'h0, autodone_reg, pscs_rsvd_reg,
                resolved_speed_duplex_reg, 2'h0};
            default: rd_data = 16'h0000;
        endcase
    end
endmodule : pvr_regs

// ### pvr_pkg.sv
package pvr_pkg;
    // ********************************
    // register offsets on the management bus
    // ********************************
    localparam logic [4:0] REG_SPECIAL_MODES = 5'h12;
    localparam logic [4:0] REG_SPECIAL_CTRL = 5'h1b;
    localparam logic [4:0] REG_IRQ_SOURCE = 5'h1d;
    localparam logic [4:0] REG_IRQ_MASK = 5'h1e;
    localparam logic [4:0] REG_PHY_SCS = 5'h1f;

    // ********************************
    // field positions and reset values
    // ********************************
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 5;
    localparam int ADDR_MSB = 4;
    localparam int SCI_PLL_BIT = 10;
    localparam int SCI_POL_BIT = 4;
    localparam int PSCS_DONE_BIT = 12;
    localparam logic [2:0] MODE_RESET = 3'h7;
    localparam logic [4:0] STATION_ADDR_RESET = 5'h01;
    localparam logic [7:0] MODES_RSVD_RESET = 8'h00;
    localparam logic [3:0] SCI_FIXED_LOW = 4'hb;
    localparam logic [6:0] PSCS_RSVD_RESET = 7'h02;
    localparam logic [6:0] COND_RESET = 7'h48;

    // ********************************
    // operating modes and their defaults
    // ********************************
    localparam logic [2:0] MODE_10_HALF = 3'h0;
    localparam logic [2:0] MODE_10_FULL = 3'h1;
    localparam logic [2:0] MODE_100_HALF = 3'h2;
    localparam logic [2:0] MODE_100_FULL = 3'h3;
    localparam logic [2:0] MODE_AN_100_HALF = 3'h4;
    localparam logic [2:0] MODE_REPEATER = 3'h5;
    localparam logic [2:0] MODE_ALL_CAPABLE = 3'h7;
    localparam logic [3:0] CTRL_10_HALF = 4'h0;
    localparam logic [3:0] CTRL_10_FULL = 4'h1;
    localparam logic [3:0] CTRL_100_HALF = 4'h8;
    localparam logic [3:0] CTRL_100_FULL = 4'h9;
    localparam logic [3:0] CTRL_AN_100_HALF = 4'hc;
    localparam logic [3:0] CTRL_ALL_CAPABLE = 4'hd;
    localparam logic [3:0] ADV_NONE = 4'h0;
    localparam logic [3:0] ADV_100_HALF = 4'h4;
    localparam logic [3:0] ADV_ALL = 4'hf;

    // ********************************
    // serial management framing
    // ********************************
    localparam logic [5:0] PREAMBLE_ONES = 6'd32;
    localparam logic [3:0] HDR_LAST = 4'd12;
    localparam logic [3:0] DATA_LAST = 4'd15;
    localparam logic [1:0] OP_READ = 2'b10;
    localparam logic [1:0] OP_WRITE = 2'b01;

    // ********************************
    // timing
    // ********************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int ENERGY_TIMEOUT_MS = 256;
    localparam int ENERGY_TIMEOUT_CYCLES =
        ENERGY_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int ENERGY_CNT_W = 24;

    typedef enum logic [2:0] {
        ST_PRE,
        ST_HDR,
        ST_TA,
        ST_RDATA,
        ST_WDATA
    } pvr_mdio_state_t;
endpackage : pvr_pkg

// ### pvr_sync.sv
`timescale 1ns/1ns
module pvr_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : pvr_sync

// ### pvr_energy.sv
`timescale 1ns/1ns
module pvr_energy
    import pvr_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = ENERGY_TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic energy_seen,
    output logic line_energy_present
);
    logic [ENERGY_CNT_W-1:0] idle_cnt_reg;

    // present is set by hardware reset or energy seen, soft reset leaves it alone
    always_ff @(posedge clk) begin
        if (rst) begin
            idle_cnt_reg <= '0;
            line_energy_present <= 1'b1;
        end else if (energy_seen) begin
            idle_cnt_reg <= '0;
            line_energy_present <= 1'b1;
        end else if (line_energy_present) begin
            if (idle_cnt_reg == ENERGY_CNT_W'(TIMEOUT_CYCLES - 1)) begin
                line_energy_present <= 1'b0;
            end else begin
                idle_cnt_reg <= idle_cnt_reg + 1'b1;
            end
        end
    end
endmodule : pvr_energy

// ### pvr_regs_properties.sv
`timescale 1ns/1ns
module pvr_regs_properties
    import pvr_pkg::*;
#(
    parameter int ENERGY_CYCLES = ENERGY_TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic soft_rst,
    input wire logic energy_seen,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic irq,
    input wire logic line_energy_present,
    input wire logic [2:0] mode_reg,
    input wire logic [4:0] station_address_field_reg,
    input wire logic force_10m_pll_reference_lock_reg,
    input wire logic [3:0] ctrl_default_reg,
    input wire logic [3:0] adv_default_reg,
    input wire logic crs_on_transmit_reg,
    input wire logic repeater_mode_reg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ********************************
    // cycles since line energy was last seen
    // ********************************
    int quiet_reg;
    always_ff @(posedge clk) begin
        if (rst || energy_seen) begin
            quiet_reg <= 0;
        end else if (quiet_reg < ENERGY_CYCLES + 8) begin
            quiet_reg <= quiet_reg + 1;
        end
    end

    // ********************************
    // properties
    // ********************************
    sequence s_soft_pulse;
        soft_rst ##1 !soft_rst;
    endsequence
    sequence s_ta_zero;
        (mdio_oe && !mdio_out) [*8];
    endsequence

    property p_fixed_mode;
        !mode_reg[2] |=> ctrl_default_reg ==
            {$past(mode_reg[1]), 2'h0, $past(mode_reg[0])};
    endproperty
    a_fixed_mode: assert property (p_fixed_mode)
        else $error("fixed mode control defaults wrong");
    property p_neg_mode;
        mode_reg[2:1] == 2'h2 |=> ctrl_default_reg == 4'hc &&
            adv_default_reg == 4'h4 && repeater_mode_reg == $past(mode_reg[0]);
    endproperty
    a_neg_mode: assert property (p_neg_mode)
        else $error("negotiating mode defaults wrong");
    property p_all_mode;
        mode_reg == 3'h7 |=> ctrl_default_reg[2:1] == 2'h2 &&
            adv_default_reg == 4'hf && !repeater_mode_reg;
    endproperty
    a_all_mode: assert property (p_all_mode)
        else $error("all capable defaults wrong");
    property p_crs;
        mode_reg inside {3'h2, 3'h3, 3'h4, 3'h5} |=>
            crs_on_transmit_reg == !$past(mode_reg[0]);
    endproperty
    a_crs: assert property (p_crs)
        else $error("carrier sense mode wrong");
    property p_soft_keep;
        soft_rst |=> $stable(mode_reg) && $stable(station_address_field_reg)
            && $stable(force_10m_pll_reference_lock_reg);
    endproperty
    a_soft_keep: assert property (p_soft_keep)
        else $error("soft reset changed a kept field");
    property p_irq_soft;
        s_soft_pulse |-> !irq ##1 !irq;
    endproperty
    a_irq_soft: assert property (p_irq_soft)
        else $error("interrupt survived soft reset");
    property p_ta_zero;
        $rose(mdio_oe) |-> s_ta_zero;
    endproperty
    a_ta_zero: assert property (p_ta_zero)
        else $error("turnaround zero not held");
    property p_energy_drop;
        quiet_reg == ENERGY_CYCLES + 4 |-> !line_energy_present;
    endproperty
    a_energy_drop: assert property (p_energy_drop)
        else $error("energy indication did not drop");
    property p_energy_hold;
        quiet_reg > 3 && quiet_reg < ENERGY_CYCLES - 3 |-> line_energy_present;
    endproperty
    a_energy_hold: assert property (p_energy_hold)
        else $error("energy indication dropped early");
endmodule : pvr_regs_properties

bind pvr_regs pvr_regs_properties #(.ENERGY_CYCLES(ENERGY_CYCLES))
    u_props (.*);

// ### pvr_mgmt_master.sv
`timescale 1ns/1ns
module pvr_mgmt_master (
    input wire logic clk,
    input wire logic mdio,
    output logic mdc,
    output logic drv,
    output logic en
);
    // ********************************
    // one mdc period of 10 clk, line sampled at the rise
    // ********************************
    initial begin
        mdc = 1'b0;
        drv = 1'b1;
        en = 1'b0;
    end

    task automatic bit_io(input logic d, input logic oe, output logic s);
        drv <= d;
        en <= oe;
        repeat (5) @(posedge clk);
        mdc <= 1'b1;
        s = mdio;
        repeat (5) @(posedge clk);
        mdc <= 1'b0;
    endtask : bit_io

    // full frame; line released for turnaround and data on reads
    task automatic frame(input logic [13:0] hdr, input logic rd,
            input logic [15:0] wd, output logic [15:0] rdat);
        logic s;
        for (int i = 0; i < 32; i++)
            bit_io(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--)
            bit_io(hdr[i], 1'b1, s);
        bit_io(1'b1, !rd, s);
        bit_io(1'b0, !rd, s);
        for (int i = 15; i >= 0; i--) begin
            bit_io(wd[i], !rd, s);
            rdat[i] = s;
        end
        en <= 1'b0;
    endtask : frame
endmodule : pvr_mgmt_master

// ### pvr_regs_tb.sv
`timescale 1ns/1ns
module pvr_regs_tb
    import pvr_pkg::*;
;
    localparam int ENERGY_CYCLES = 50;
    logic clk, rst, soft_rst, mdc, mdio_out, mdio_oe, m_drv, m_en, irq;
    logic energy_seen, an_enable, an_complete, remote_fault, link_up;
    logic partner_ack, parallel_detect_fault, page_received;
    logic polarity_reversed_in, link_speed_100, link_full_duplex;
    logic line_energy_present, force_10m_pll_reference_lock_reg;
    logic crs_on_transmit_reg, repeater_mode_reg;
    logic [2:0] mode_reg;
    logic [4:0] station_address_field_reg;
    logic [3:0] ctrl_default_reg, adv_default_reg;
    wire logic mdio_in;
    int err_count = 0;
    int n_compared = 0;
    logic [3:0] ctrl_tab [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hc, 4'hc, 4'h0,
        4'hd};
    logic [2:0] spd_tab [4] = '{3'h1, 3'h2, 3'h5, 3'h6};

    // pull-up when nobody drives the line
    assign mdio_in = mdio_oe ? mdio_out : (m_en ? m_drv : 1'b1);

    pvr_regs #(.ENERGY_CYCLES(ENERGY_CYCLES)) uut (.*);
    pvr_mgmt_master mgr (.clk(clk), .mdio(mdio_in), .mdc(mdc),
        .drv(m_drv), .en(m_en));

    always #10 clk = ~clk;

    // ********************************
    // access and compare tasks
    // ********************************
    task automatic report_and_stop;
        $display("TB: errors=%0d compared=%0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rc(input logic [4:0] pa, input logic [4:0] ra,
            input logic [15:0] exp);
        logic [15:0] d;
        mgr.frame({2'b01, OP_READ, pa, ra}, 1'b1, 16'h0, d);
        chk(d, exp);
    endtask : rc

    task automatic wr(input logic [4:0] pa, input logic [4:0] ra,
            input logic [15:0] d);
        logic [15:0] x;
        mgr.frame({2'b01, OP_WRITE, pa, ra}, 1'b0, d, x);
        repeat (6) @(posedge clk);
    endtask : wr

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    // ********************************
    // main sequence
    // ********************************
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        soft_rst = 1'b0;
        energy_seen = 1'b1;
        {an_enable, an_complete, remote_fault, partner_ack} = 4'h0;
        {parallel_detect_fault, page_received, polarity_reversed_in} = 3'h0;
        {link_speed_100, link_full_duplex} = 2'h0;
        link_up = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rc(5'h01, REG_SPECIAL_MODES, 16'h00e1);
        rc(5'h01, REG_IRQ_MASK, 16'h0000);
        rc(5'h01, REG_PHY_SCS, 16'h0044);
        wr(5'h01, REG_PHY_SCS, 16'h0040);
        for (int m = 0; m < 8; m++) begin
            if (m == 6)
                continue;
            wr(5'h01, REG_SPECIAL_MODES, {8'h00, 3'(m), 5'h01});
            chk(ctrl_default_reg, ctrl_tab[m]);
            if (m >= 4)
                chk(adv_default_reg, (m == 7) ? 4'hf : 4'h4);
            chk(repeater_mode_reg, m == 5);
            if (m >= 2 && m <= 5)
                chk(crs_on_transmit_reg, !m[0]);
            rc(5'h01, REG_SPECIAL_MODES, {8'h00, 3'(m), 5'h01});
        end
        wr(5'h01, REG_SPECIAL_MODES, 16'h00e3);
        rc(5'h01, REG_SPECIAL_MODES, 16'hffff);
        rc(5'h03, REG_SPECIAL_MODES, 16'h00e3);
        wr(5'h03, REG_SPECIAL_MODES, 16'h00e1);
        rc(5'h01, 5'h05, 16'hffff);
        wr(5'h01, REG_SPECIAL_CTRL, 16'h0404);
        rc(5'h01, REG_SPECIAL_CTRL, 16'h040b);
        chk(force_10m_pll_reference_lock_reg, 1'b1);
        polarity_reversed_in <= 1'b1;
        rc(5'h01, REG_SPECIAL_CTRL, 16'h041b);
        for (int s = 0; s < 4; s++) begin
            {link_full_duplex, link_speed_100} <= 2'(s);
            an_enable <= 1'b1;
            an_complete <= s[1];
            rc(5'h01, REG_PHY_SCS, {3'h0, s[1], 7'h02, spd_tab[s], 2'h0});
        end
        an_enable <= 1'b0;
        rc(5'h01, REG_PHY_SCS, 16'h0058);
        an_complete <= 1'b0;
        wr(5'h01, REG_IRQ_MASK, 16'h00ff);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk({mode_reg, station_address_field_reg}, 8'he1);
        rc(5'h01, REG_SPECIAL_CTRL, 16'h041b);
        rc(5'h01, REG_IRQ_MASK, 16'h0000);
        rc(5'h01, REG_IRQ_SOURCE, 16'h0000);
        {an_enable, an_complete, remote_fault, partner_ack} <= 4'hf;
        {parallel_detect_fault, page_received, link_up} <= 3'h6;
        energy_seen <= 1'b0;
        repeat (ENERGY_CYCLES + 10) @(posedge clk);
        chk(line_energy_present, 1'b0);
        chk(irq, 1'b0);
        wr(5'h01, REG_IRQ_MASK, 16'h0002);
        chk(irq, 1'b1);
        rc(5'h01, REG_IRQ_SOURCE, 16'h00fe);
        chk(irq, 1'b0);
        rc(5'h01, REG_IRQ_SOURCE, 16'h0000);
        energy_seen <= 1'b1;
        repeat (6) @(posedge clk);
        chk(irq, 1'b0);
        wr(5'h01, REG_IRQ_MASK, 16'h0080);
        chk(irq, 1'b1);
        rc(5'h01, REG_IRQ_SOURCE, 16'h0080);
        report_and_stop();
    end
endmodule : pvr_regs_tb
